// ### hw/sfc_pkg.sv
/*
 * sfc_pkg: register map, field positions, reset values and carrier types
 * of the sample buffer control block.
 * assumes: a 16-bit register port addressed by register index.
 */
package sfc_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int WORD_W = 24;
   localparam int LEVEL_W = 14;
   localparam int IRQ_W = 4;

   // register indexes
   localparam logic [ADDR_W-1:0] ADDR_CONTROL_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_THRESHOLD = 8'h11;
   localparam logic [ADDR_W-1:0] ADDR_TEST_WRITE = 8'h12;
   localparam logic [ADDR_W-1:0] ADDR_ERROR = 8'h15;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h20;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h21;

   // buffer_control_status fields
   localparam int BIT_RESET = 15;
   localparam int BIT_UNDERFLOW = 14;
   localparam int BIT_OVERFLOW = 13;
   localparam int BIT_FULL = 12;
   localparam int BIT_ALMOST_FULL = 11;
   localparam int BIT_EMPTY = 10;
   localparam int COUNT_LSB = 0;
   localparam int COUNT_BITS = 8;

   // error register fields
   localparam int BIT_CLEAR_ERRORS = 15;
   localparam int BIT_ERR_UNDERFLOW = 7;
   localparam int BIT_ERR_OVERFLOW = 6;

   // test write pairing
   localparam int LOW_BITS = 16;
   localparam int HIGH_BITS = 8;

   // interrupt status and mask bits
   localparam int IRQ_OVERFLOW = 0;
   localparam int IRQ_UNDERFLOW = 1;
   localparam int IRQ_ALMOST_FULL = 2;
   localparam int IRQ_RESET_DONE = 3;

   // buffer reset length in clock cycles
   localparam int RST_CNT_W = 3;
   localparam logic [RST_CNT_W-1:0] RESET_CYCLES = 3'h4;
   localparam logic [RST_CNT_W-1:0] RESET_LAST = 3'h1;

   localparam logic [LEVEL_W-1:0] THRESHOLD_RESET = 14'h0000;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
   localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

   typedef struct packed {
      logic                wr;
      logic                rd;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
   } sfc_reg_req_t;

   typedef struct packed {
      logic                valid;
      logic [WORD_W-1:0]   data;
   } sfc_sample_t;

endpackage : sfc_pkg

// ### hw/sfc_sample_fifo_control.sv
/*
 * sfc_sample_fifo_control: sample buffer with self-clearing buffer reset,
 * full, almost-full and empty flags, guarded overflow and underflow,
 * a paired test write path, error bits and a masked interrupt.
 * assumes: one clock, register strobes one cycle long and never together,
 * acquisition writes and host pops arrive as one-cycle requests.
 */
module sfc_sample_fifo_control #(
   parameter int DEPTH = 64
) (
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   input  wire sfc_pkg::sfc_reg_req_t regReq,
   output      logic [15:0]        regRdData,
   input  wire sfc_pkg::sfc_sample_t  acqSample,
   input  wire logic               acqIdle,
   input  wire logic               popReq,
   output      sfc_pkg::sfc_sample_t  popSample,
   output      logic               irq
);
   import sfc_pkg::*;

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam int LW = (CW > LEVEL_W) ? CW + 1 : LEVEL_W + 1;
   localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
   localparam logic [CW-1:0] COUNT_MAX = CW'(DEPTH);

   // buffer reset sequencer states
   typedef enum logic {
      FLUSH_IDLE,
      FLUSH_RUN
   } sfc_flush_state_t;

   function automatic logic hit(
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] target
   );
      hit = (addr == target);
   endfunction : hit

   function automatic logic [AW-1:0] advance(input logic [AW-1:0] ptr);
      advance = (ptr == PTR_LAST) ? '0 : ptr + AW'(1);
   endfunction : advance

   logic [WORD_W-1:0]    mem [DEPTH];
   logic [AW-1:0]        wrPtr;
   logic [AW-1:0]        rdPtr;
   logic [CW-1:0]        count;
   sfc_flush_state_t     flushState;
   logic                 resetBusy;
   logic [RST_CNT_W-1:0] resetCnt;
   logic [LEVEL_W-1:0]   threshold;
   logic [LEVEL_W-1:0]   activeLevel;
   logic                 underflowFlag;
   logic                 overflowFlag;
   logic                 errUnderflow;
   logic                 errOverflow;
   logic                 testHalf;
   logic [LOW_BITS-1:0]  testLow;
   logic [IRQ_W-1:0]     irqStatus;
   logic [IRQ_W-1:0]     irqMask;
   logic                 almostFullPrev;

   logic                 wrControl;
   logic                 wrThreshold;
   logic                 wrTest;
   logic                 wrError;
   logic                 wrIrqStatus;
   logic                 wrIrqMask;
   logic                 resetStart;
   logic                 resetDone;
   logic                 testPush;
   logic                 pushReq;
   logic [WORD_W-1:0]    pushData;
   logic                 fullFlag;
   logic                 emptyFlag;
   logic                 almostFullFlag;
   logic                 pushOk;
   logic                 popOk;
   logic                 pushReject;
   logic                 popReject;
   logic                 clearErrors;
   logic [IRQ_W-1:0]     irqEvents;

   // register write decode
   always_comb begin
      wrControl   = regReq.wr && hit(regReq.addr, ADDR_CONTROL_STATUS);
      wrThreshold = regReq.wr && hit(regReq.addr, ADDR_THRESHOLD);
      wrTest      = regReq.wr && hit(regReq.addr, ADDR_TEST_WRITE);
      wrError     = regReq.wr && hit(regReq.addr, ADDR_ERROR);
      wrIrqStatus = regReq.wr && hit(regReq.addr, ADDR_IRQ_STATUS);
      wrIrqMask   = regReq.wr && hit(regReq.addr, ADDR_IRQ_MASK);
   end

   assign resetBusy   = (flushState == FLUSH_RUN);
   assign resetStart  = wrControl && regReq.wdata[BIT_RESET] && !resetBusy;
   assign resetDone   = resetBusy && (resetCnt == RESET_LAST);
   assign clearErrors = wrError && regReq.wdata[BIT_CLEAR_ERRORS];

   // buffer state flags
   assign fullFlag  = (count == COUNT_MAX);
   assign emptyFlag = (count == '0);
   assign almostFullFlag = (activeLevel != '0)
      && (LW'(count) >= LW'(activeLevel));

   // push source: acquisition datapath or completed test pair
   assign testPush = wrTest && acqIdle && testHalf;
   assign pushReq  = !resetBusy && (acqSample.valid || testPush);
   assign pushData = testPush
      ? {regReq.wdata[HIGH_BITS-1:0], testLow}
      : acqSample.data;

   assign pushOk     = pushReq && !fullFlag;
   assign pushReject = pushReq && fullFlag;
   assign popOk      = !resetBusy && popReq && !emptyFlag;
   assign popReject  = !resetBusy && popReq && emptyFlag;

   // buffer reset sequencer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flushState <= FLUSH_IDLE;
         resetCnt   <= '0;
      end else begin
         unique case (flushState)
            FLUSH_IDLE: begin
               if (resetStart) begin
                  flushState <= FLUSH_RUN;
                  resetCnt   <= RESET_CYCLES;
               end
            end
            FLUSH_RUN: begin
               if (resetDone) begin
                  flushState <= FLUSH_IDLE;
                  resetCnt   <= '0;
               end else begin
                  resetCnt <= resetCnt - RST_CNT_W'(1);
               end
            end
         endcase
      end
   end

   // threshold register and the level in force
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         threshold   <= THRESHOLD_RESET;
         activeLevel <= THRESHOLD_RESET;
      end else begin
         if (wrThreshold) begin
            threshold <= regReq.wdata[LEVEL_W-1:0];
         end
         if (resetBusy) begin
            activeLevel <= threshold;
         end
      end
   end

   // sample storage, written only on an accepted push
   always_ff @(posedge clk_sys) begin
      if (pushOk) begin
         mem[wrPtr] <= pushData;
      end
   end

   // pointers and count
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else if (resetBusy) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (pushOk) begin
            wrPtr <= advance(wrPtr);
         end
         if (popOk) begin
            rdPtr <= advance(rdPtr);
         end
         if (pushOk && !popOk) begin
            count <= count + CW'(1);
         end else if (popOk && !pushOk) begin
            count <= count - CW'(1);
         end
      end
   end

   // pop answer, one cycle after the request
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         popSample <= '0;
      end else begin
         popSample.valid <= popOk;
         if (popOk) begin
            popSample.data <= mem[rdPtr];
         end
      end
   end

   // test write pairing
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         testHalf <= 1'b0;
         testLow  <= '0;
      end else if (resetBusy) begin
         testHalf <= 1'b0;
         testLow  <= '0;
      end else if (wrTest && acqIdle) begin
         testHalf <= !testHalf;
         if (!testHalf) begin
            testLow <= regReq.wdata[LOW_BITS-1:0];
         end
      end
   end

   // control-register error flags, cleared by buffer reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         underflowFlag <= 1'b0;
         overflowFlag  <= 1'b0;
      end else begin
         if (popReject) begin
            underflowFlag <= 1'b1;
         end else if (resetBusy) begin
            underflowFlag <= 1'b0;
         end
         if (pushReject) begin
            overflowFlag <= 1'b1;
         end else if (resetBusy) begin
            overflowFlag <= 1'b0;
         end
      end
   end

   // error register bits, latched until the clear command
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         errUnderflow <= 1'b0;
         errOverflow  <= 1'b0;
      end else begin
         if (popReject) begin
            errUnderflow <= 1'b1;
         end else if (clearErrors) begin
            errUnderflow <= 1'b0;
         end
         if (pushReject) begin
            errOverflow <= 1'b1;
         end else if (clearErrors) begin
            errOverflow <= 1'b0;
         end
      end
   end

   // interrupt events, sticky status and mask
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         almostFullPrev <= 1'b0;
      end else begin
         almostFullPrev <= almostFullFlag;
      end
   end

   always_comb begin
      irqEvents                  = '0;
      irqEvents[IRQ_OVERFLOW]    = pushReject;
      irqEvents[IRQ_UNDERFLOW]   = popReject;
      irqEvents[IRQ_ALMOST_FULL] = almostFullFlag && !almostFullPrev;
      irqEvents[IRQ_RESET_DONE]  = resetDone;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irqStatus <= IRQ_RESET;
      end else if (wrIrqStatus) begin
         irqStatus <= (irqStatus & ~regReq.wdata[IRQ_W-1:0]) | irqEvents;
      end else begin
         irqStatus <= irqStatus | irqEvents;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irqMask <= IRQ_RESET;
      end else if (wrIrqMask) begin
         irqMask <= regReq.wdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStatus & irqMask);
      end
   end

   // register read, data in the cycle after the strobe only
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= READ_ZERO;
      end else begin
         regRdData <= READ_ZERO;
         if (regReq.rd) begin
            if (hit(regReq.addr, ADDR_CONTROL_STATUS)) begin
               regRdData[BIT_RESET]       <= resetBusy;
               regRdData[BIT_UNDERFLOW]   <= underflowFlag;
               regRdData[BIT_OVERFLOW]    <= overflowFlag;
               regRdData[BIT_FULL]        <= fullFlag;
               regRdData[BIT_ALMOST_FULL] <= almostFullFlag;
               regRdData[BIT_EMPTY]       <= emptyFlag;
               regRdData[COUNT_LSB +: COUNT_BITS] <=
                  COUNT_BITS'(count);
            end else if (hit(regReq.addr, ADDR_THRESHOLD)) begin
               regRdData[LEVEL_W-1:0] <= threshold;
            end else if (hit(regReq.addr, ADDR_ERROR)) begin
               regRdData[BIT_ERR_UNDERFLOW] <= errUnderflow;
               regRdData[BIT_ERR_OVERFLOW]  <= errOverflow;
            end else if (hit(regReq.addr, ADDR_IRQ_STATUS)) begin
               regRdData[IRQ_W-1:0] <= irqStatus;
            end else if (hit(regReq.addr, ADDR_IRQ_MASK)) begin
               regRdData[IRQ_W-1:0] <= irqMask;
            end
         end
      end
   end

endmodule : sfc_sample_fifo_control

// ### tb/sfc_fifo_assertions.sv
/* sfc_fifo_checker: port assertions of the sample buffer control.
 * assumes: bound to sfc_sample_fifo_control, one clock domain. */
module sfc_fifo_checker
   import sfc_pkg::*;
#(
   parameter int DEPTH = 8
) (
   input wire logic                  clk_sys,
   input wire logic                  rst_n,
   input wire sfc_pkg::sfc_reg_req_t regReq,
   input wire logic [15:0]           regRdData,
   input wire logic                  popReq,
   input wire sfc_pkg::sfc_sample_t  popSample
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] FULL_CNT = 8'(DEPTH);
   logic rdCtl;
   logic rdAft;
   logic rdTw;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // which register the answer on regRdData belongs to
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdCtl <= 1'b0;
         rdAft <= 1'b0;
         rdTw <= 1'b0;
      end else begin
         rdCtl <= regReq.rd && regReq.addr == ADDR_CONTROL_STATUS;
         rdAft <= regReq.rd && regReq.addr == ADDR_THRESHOLD;
         rdTw <= regReq.rd && regReq.addr == ADDR_TEST_WRITE;
      end
   end
   property p_ctl_rsvd;
      rdCtl |-> regRdData[9:8] == 2'h0;
   endproperty
   a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("ctl 9:8");
   property p_aft_rsvd;
      rdAft |-> regRdData[15:14] == 2'h0;
   endproperty
   a_aft_rsvd: assert property (p_aft_rsvd) else $error("aft 15:14");
   property p_tw_wo;
      rdTw |-> regRdData == 16'h0000;
   endproperty
   a_tw_wo: assert property (p_tw_wo) else $error("test write read");
   property p_full_empty;
      rdCtl |-> !(regRdData[BIT_FULL] && regRdData[BIT_EMPTY]);
   endproperty
   a_full_empty: assert property (p_full_empty) else $error("full+empty");
   property p_full_cnt;
      rdCtl && regRdData[BIT_FULL] |-> regRdData[7:0] == FULL_CNT;
   endproperty
   a_full_cnt: assert property (p_full_cnt) else $error("full count");
   property p_empty_cnt;
      rdCtl && regRdData[BIT_EMPTY] |-> regRdData[7:0] == 8'h00;
   endproperty
   a_empty_cnt: assert property (p_empty_cnt) else $error("empty count");
   property p_flush_pop;
      (regReq.wr && regReq.addr == ADDR_CONTROL_STATUS
         && regReq.wdata[BIT_RESET]) ##[1:3] popReq |=> !popSample.valid;
   endproperty
   a_flush_pop: assert property (p_flush_pop) else $error("pop in reset");
   property p_pop_valid;
      popSample.valid |-> $past(popReq);
   endproperty
   a_pop_valid: assert property (p_pop_valid) else $error("stray valid");
endmodule : sfc_fifo_checker

bind sfc_sample_fifo_control sfc_fifo_checker #(.DEPTH(DEPTH)) u_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .regReq(regReq),
   .regRdData(regRdData), .popReq(popReq), .popSample(popSample));

// ### tb/sfc_acq_model.sv
/* sfc_acq_model: acquisition writer and host reader of the buffer.
 * assumes: the bench drives it through its tasks. */
module sfc_acq_model (
   input wire logic                 clk_sys,
   output     sfc_pkg::sfc_sample_t acqSample,
   output     logic                 acqIdle,
   output     logic                 popReq,
   input wire sfc_pkg::sfc_sample_t popSample
);
   timeunit 1ns;
   timeprecision 1ps;
   import sfc_pkg::*;
   initial begin
      acqSample = '0;
      acqIdle = 1'b1;
      popReq = 1'b0;
   end
   // one word per pulse; released data shows its inverse
   task automatic push(input logic [WORD_W-1:0] w);
      @(posedge clk_sys);
      acqSample <= '{valid: 1'b1, data: w};
      @(posedge clk_sys);
      acqSample <= '{valid: 1'b0, data: ~w};
   endtask : push
   task automatic pop(output sfc_sample_t s);
      @(posedge clk_sys);
      popReq <= 1'b1;
      @(posedge clk_sys);
      popReq <= 1'b0;
      #1 s = popSample;
   endtask : pop
   task automatic set_idle(input logic i);
      @(posedge clk_sys);
      acqIdle <= i;
   endtask : set_idle
endmodule : sfc_acq_model

// ### tb/tb_sample_fifo_control.sv
/* tb_sample_fifo_control: register-level tests of the buffer control.
 * assumes: sfc_pkg, the design and sfc_acq_model are compiled first. */
module tb_sample_fifo_control;
   timeunit 1ns;
   timeprecision 1ps;
   import sfc_pkg::*;
   logic         clk_sys;
   logic         rst_n;
   logic         irq;
   logic         acqIdle;
   logic         popReq;
   logic [15:0]  regRdData;
   logic [15:0]  d;
   sfc_reg_req_t regReq;
   sfc_sample_t  acqSample;
   sfc_sample_t  popSample;
   sfc_sample_t  s;
   int           nErrors = 0;
   int           compares = 0;
   localparam logic [7:0] CTL = ADDR_CONTROL_STATUS;
   sfc_sample_fifo_control #(.DEPTH(8)) DUT (.clk_sys(clk_sys),
      .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
      .acqSample(acqSample), .acqIdle(acqIdle), .popReq(popReq),
      .popSample(popSample), .irq(irq));
   sfc_acq_model P (.clk_sys(clk_sys), .acqSample(acqSample),
      .acqIdle(acqIdle), .popReq(popReq), .popSample(popSample));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge clk_sys);
      regReq <= '0;
   endtask : wr
   task automatic chk_reg(input string n, input logic [15:0] e, g);
      compares++;
      if (g !== e) begin
         nErrors++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask : chk_reg
   task automatic chk_smp(input string n, input sfc_sample_t e, g);
      compares++;
      if (g !== e) begin
         nErrors++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask : chk_smp
   task automatic rc(input string n, input logic [7:0] a,
                     input logic [15:0] e);
      @(posedge clk_sys);
      regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge clk_sys);
      regReq <= '0;
      #1 d = regRdData;
      chk_reg(n, e, d);
   endtask : rc
   task automatic endSim;
      $display("errors %0d compares %0d", nErrors, compares);
      if (nErrors == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : endSim
   initial begin
      repeat (5000) @(posedge clk_sys);
      nErrors++;
      endSim;
   end
   initial begin
      rst_n = 1'b0;
      regReq = '0;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      rc("ctl", CTL, 16'h0400);
      rc("aft", ADDR_THRESHOLD, 16'h0000);
      wr(ADDR_THRESHOLD, 16'hFFFF);
      rc("aft", ADDR_THRESHOLD, 16'h3FFF);
      rc("tw", ADDR_TEST_WRITE, 16'h0000);
      rc("unmapped", 8'h7F, 16'h0000);
      wr(ADDR_THRESHOLD, 16'h0003);
      wr(CTL, 16'h8000);
      rc("busy", CTL, 16'h8400);
      repeat (4) @(posedge clk_sys);
      rc("done", CTL, 16'h0400);
      for (int i = 1; i <= 9; i++) begin
         P.push(24'(i));
         if (i == 2) rc("cnt", CTL, 16'h0002);
         if (i == 3) rc("af", CTL, 16'h0803);
         if (i == 8) rc("full", CTL, 16'h1808);
      end
      rc("ovf", CTL, 16'h3808);
      rc("errOvf", ADDR_ERROR, 16'h0040);
      chk_reg("irq", 16'h0000, {15'h0000, irq});
      rc("irqSt", ADDR_IRQ_STATUS, 16'h000D);
      wr(ADDR_IRQ_MASK, 16'h0001);
      rc("irqMask", ADDR_IRQ_MASK, 16'h0001);
      chk_reg("irq", 16'h0001, {15'h0000, irq});
      wr(ADDR_IRQ_STATUS, 16'h000F);
      rc("irqSt", ADDR_IRQ_STATUS, 16'h0000);
      chk_reg("irq", 16'h0000, {15'h0000, irq});
      for (int i = 1; i <= 9; i++) begin
         P.pop(s);
         chk_smp("pop", {1'(i < 9), 24'(i < 9 ? i : 8)}, s);
         if (i == 6) rc("afOff", CTL, 16'h2002);
      end
      rc("unf", CTL, 16'h6400);
      rc("errUnf", ADDR_ERROR, 16'h00C0);
      wr(ADDR_ERROR, 16'h8000);
      rc("errClr", ADDR_ERROR, 16'h0000);
      P.push(24'h00000A);
      P.push(24'h00000B);
      wr(CTL, 16'h8000);
      P.pop(s);
      chk_reg("flushPop", 16'h0000, {15'h0000, s.valid});
      repeat (2) @(posedge clk_sys);
      rc("flushed", CTL, 16'h0400);
      P.set_idle(1'b0);
      wr(ADDR_TEST_WRITE, 16'h1111);
      wr(ADDR_TEST_WRITE, 16'h2222);
      rc("notIdle", CTL, 16'h0400);
      P.set_idle(1'b1);
      wr(ADDR_TEST_WRITE, 16'hBEEF);
      rc("half", CTL, 16'h0400);
      wr(ADDR_TEST_WRITE, 16'h12A5);
      rc("pair", CTL, 16'h0001);
      P.pop(s);
      chk_smp("pairPop", {1'b1, 24'hA5BEEF}, s);
      endSim;
   end
endmodule : tb_sample_fifo_control
